//--- hw/lvd_pkg.sv
package lvd_pkg;
    // Register indices on the plain register port
    localparam logic [1:0] LVD_ADDR_CTRL = 2'h0;
    localparam logic [1:0] LVD_ADDR_MFI = 2'h1;
    localparam int LVD_AW = 2;
    // Control register fields
    localparam int CTRL_FLAG_BIT = 5;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_SEL_LSB = 0;
    localparam int SEL_W = 3;
    localparam logic [7:0] CTRL_WMASK = 8'h17;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Multi-function group fields
    localparam int MFI_REQ_BIT = 4;
    localparam int MFI_EN_BIT = 0;
    localparam logic [7:0] MFI_RESET = 8'h00;
    // Trip voltages in millivolts by select code
    localparam logic [15:0] TRIP_MV [8] = '{16'd1800, 16'd2000, 16'd2400, 16'd2700,
                                           16'd3000, 16'd3300, 16'd3600, 16'd4000};
    // Interrupt delay after the flag rises
    localparam int IRQ_DELAY_NS = 15000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int IRQ_DELAY_CYC = (IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    typedef struct packed {
        logic [LVD_AW-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lvd_bus_req_t;
endpackage : lvd_pkg

//--- hw/lvd_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Enable bit 4 turns the detector on; clearing it turns it off.
// - Three-bit select picks one of eight trip voltages, 1.8V up to 4.0V.
// - Bit 5 flag reads 1 on low supply, else 0; writes ignored.
// - Bits 7, 6 and 3 of the control register always read zero.
// - Comparator reporting supply below threshold sets the flag.
// - In SLEEP the detector stays off even with enable set.
// - Interrupt request is reported through a multi-function group register.
// - Hardware sets the request flag only after the interrupt delay following flag rise; a software write can set it at any time.
// - A request newly raised by hardware while IDLE wakes the core.
// - Flag follows the comparator without hysteresis or filtering.
// - Request flag at bit 4, enable at bit 0 of group register, both R/W.
module lvd_ctrl #(
    parameter int DELAY_CYC = lvd_pkg::IRQ_DELAY_CYC
) (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire lvd_pkg::lvd_bus_req_t bus_i,
    output logic [7:0] rdata_o,
    input wire logic cmp_low_i,
    input wire logic sleep_i,
    input wire logic idle_i,
    output logic detector_on_o,
    output logic [lvd_pkg::SEL_W-1:0] threshold_select_o,
    output logic [15:0] trip_mv_o,
    output logic mf_irq_o,
    output logic wake_o
);
    logic detector_enable_r, detector_enable_nxt;
    logic [lvd_pkg::SEL_W-1:0] threshold_select_r, threshold_select_nxt;
    logic low_voltage_flag_r, low_voltage_flag_nxt;
    logic lv_irq_request_r, lv_irq_request_nxt;
    logic lv_irq_enable_r, lv_irq_enable_nxt;
    logic [lvd_pkg::CNT_W-1:0] dly_cnt_r, dly_cnt_nxt;
    logic dly_run_r, dly_run_nxt;
    logic cmp_s1_r, cmp_s2_r;
    logic [7:0] rdata_r, rdata_nxt;
    logic on_r, on_nxt;
    logic [15:0] trip_r, trip_nxt;
    logic mf_irq_r, mf_irq_nxt;
    logic wake_r, wake_nxt;
    logic hw_set;

    function automatic logic hit(input lvd_pkg::lvd_bus_req_t b, input logic [1:0] a);
        hit = b.wr && (b.addr == a);
    endfunction : hit

    // Two-flop synchroniser for the analog comparator
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_low_i;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    always_comb begin
        detector_enable_nxt = detector_enable_r;
        threshold_select_nxt = threshold_select_r;
        lv_irq_enable_nxt = lv_irq_enable_r;
        lv_irq_request_nxt = lv_irq_request_r;
        dly_cnt_nxt = dly_cnt_r;
        dly_run_nxt = dly_run_r;
        hw_set = 1'b0;
        if (hit(bus_i, lvd_pkg::LVD_ADDR_CTRL)) begin
            detector_enable_nxt = bus_i.wdata[lvd_pkg::CTRL_EN_BIT];
            threshold_select_nxt = bus_i.wdata[lvd_pkg::CTRL_SEL_LSB +: lvd_pkg::SEL_W];
        end
        // Effective on only outside SLEEP
        on_nxt = detector_enable_nxt && !sleep_i;
        // Flag follows comparator directly, no filter; off detector reads clear
        low_voltage_flag_nxt = on_r && cmp_s2_r;
        trip_nxt = lvd_pkg::TRIP_MV[threshold_select_nxt];
        // Delay timer restarts on each rising flag and aborts if the flag drops
        if (low_voltage_flag_nxt && !low_voltage_flag_r) begin
            dly_run_nxt = 1'b1;
            dly_cnt_nxt = '0;
        end else if (!low_voltage_flag_nxt) begin
            dly_run_nxt = 1'b0;
        end else if (dly_run_r) begin
            if (dly_cnt_r == lvd_pkg::CNT_W'(DELAY_CYC - 1)) begin
                hw_set = 1'b1;
                dly_run_nxt = 1'b0;
            end else begin
                dly_cnt_nxt = dly_cnt_r + 1'b1;
            end
        end
        if (hit(bus_i, lvd_pkg::LVD_ADDR_MFI)) begin
            lv_irq_request_nxt = bus_i.wdata[lvd_pkg::MFI_REQ_BIT];
            lv_irq_enable_nxt = bus_i.wdata[lvd_pkg::MFI_EN_BIT];
        end
        if (hw_set) begin
            lv_irq_request_nxt = 1'b1;
        end
        mf_irq_nxt = lv_irq_request_nxt && lv_irq_enable_nxt;
        // Wake only on a request newly raised by hardware while idle
        wake_nxt = hw_set && !lv_irq_request_r && idle_i;
        rdata_nxt = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                lvd_pkg::LVD_ADDR_CTRL: begin
                    rdata_nxt[lvd_pkg::CTRL_FLAG_BIT] = low_voltage_flag_r;
                    rdata_nxt[lvd_pkg::CTRL_EN_BIT] = detector_enable_r;
                    rdata_nxt[lvd_pkg::CTRL_SEL_LSB +: lvd_pkg::SEL_W] = threshold_select_r;
                end
                lvd_pkg::LVD_ADDR_MFI: begin
                    rdata_nxt[lvd_pkg::MFI_REQ_BIT] = lv_irq_request_r;
                    rdata_nxt[lvd_pkg::MFI_EN_BIT] = lv_irq_enable_r;
                end
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            detector_enable_r <= 1'b0;
            threshold_select_r <= '0;
            low_voltage_flag_r <= 1'b0;
            lv_irq_request_r <= 1'b0;
            lv_irq_enable_r <= 1'b0;
            dly_cnt_r <= '0;
            dly_run_r <= 1'b0;
            rdata_r <= 8'h00;
            on_r <= 1'b0;
            trip_r <= lvd_pkg::TRIP_MV[0];
            mf_irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            detector_enable_r <= detector_enable_nxt;
            threshold_select_r <= threshold_select_nxt;
            low_voltage_flag_r <= low_voltage_flag_nxt;
            lv_irq_request_r <= lv_irq_request_nxt;
            lv_irq_enable_r <= lv_irq_enable_nxt;
            dly_cnt_r <= dly_cnt_nxt;
            dly_run_r <= dly_run_nxt;
            rdata_r <= rdata_nxt;
            on_r <= on_nxt;
            trip_r <= trip_nxt;
            mf_irq_r <= mf_irq_nxt;
            wake_r <= wake_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign detector_on_o = on_r;
    assign threshold_select_o = threshold_select_r;
    assign trip_mv_o = trip_r;
    assign mf_irq_o = mf_irq_r;
    assign wake_o = wake_r;

    property p_sleep_off;
        @(posedge clock_i) disable iff (!rst_b_i) sleep_i |=> !on_r;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("on during sleep");

    property p_en_on;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) && bus_i.wdata[4] && !sleep_i |=> on_r;
    endproperty
    a_en_on: assert property (p_en_on) else $error("enable not applied");

    property p_trip;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) && bus_i.wdata[2:0] == 3'h7
            |=> trip_r == 16'd4000;
    endproperty
    a_trip: assert property (p_trip) else $error("trip wrong");

    property p_unimpl;
        @(posedge clock_i) disable iff (!rst_b_i)
            $past(bus_i.rd) && $past(bus_i.addr) == 2'h0 |-> rdata_r[7:6] == 2'h0 && !rdata_r[3];
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits set");

    property p_flag;
        @(posedge clock_i) disable iff (!rst_b_i) on_r && cmp_s2_r |=> low_voltage_flag_r;
    endproperty
    a_flag: assert property (p_flag) else $error("flag not set");

    property p_flag_rd;
        @(posedge clock_i) disable iff (!rst_b_i)
            bus_i.rd && bus_i.addr == 2'h0 |=> rdata_r[5] == $past(low_voltage_flag_r);
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag read wrong");

    property p_no_early;
        @(posedge clock_i) disable iff (!rst_b_i)
            $rose(low_voltage_flag_r) && !lv_irq_request_r && !bus_i.wr |=> !lv_irq_request_r;
    endproperty
    a_no_early: assert property (p_no_early) else $error("request too early");

    property p_sticky;
        @(posedge clock_i) disable iff (!rst_b_i)
            lv_irq_request_r && !hit(bus_i, lvd_pkg::LVD_ADDR_MFI) |=> lv_irq_request_r;
    endproperty
    a_sticky: assert property (p_sticky) else $error("request lost");

    property p_wake;
        @(posedge clock_i) disable iff (!rst_b_i) wake_r |-> lv_irq_request_r && $past(idle_i);
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");

    // Counts how long the flag has stood high, so the delay check sees real time
    logic [lvd_pkg::CNT_W-1:0] hi_cnt_r, hi_cnt_nxt;

    always_comb begin
        hi_cnt_nxt = '0;
        if (low_voltage_flag_r) begin
            hi_cnt_nxt = (hi_cnt_r == '1) ? hi_cnt_r : hi_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hi_cnt_r <= '0;
        end else begin
            hi_cnt_r <= hi_cnt_nxt;
        end
    end

    property p_req_delay;
        @(posedge clock_i) disable iff (!rst_b_i)
            $rose(lv_irq_request_r) && !$past(hit(bus_i, lvd_pkg::LVD_ADDR_MFI))
            |-> hi_cnt_r >= lvd_pkg::CNT_W'(DELAY_CYC);
    endproperty
    a_req_delay: assert property (p_req_delay) else $error("request before delay");

    property p_req_flag_high;
        @(posedge clock_i) disable iff (!rst_b_i)
            $rose(lv_irq_request_r) && !$past(hit(bus_i, lvd_pkg::LVD_ADDR_MFI))
            |-> $past(low_voltage_flag_r);
    endproperty
    a_req_flag_high: assert property (p_req_flag_high) else $error("request without flag");

    property p_cnt_bound;
        @(posedge clock_i) disable iff (!rst_b_i)
            dly_run_r |-> dly_cnt_r < lvd_pkg::CNT_W'(DELAY_CYC);
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("delay count overrun");

    property p_run_flag;
        @(posedge clock_i) disable iff (!rst_b_i)
            dly_run_r |-> low_voltage_flag_r;
    endproperty
    a_run_flag: assert property (p_run_flag) else $error("timer runs with flag low");

    property p_off_no_flag;
        @(posedge clock_i) disable iff (!rst_b_i)
            !on_r |=> !low_voltage_flag_r;
    endproperty
    a_off_no_flag: assert property (p_off_no_flag) else $error("flag while off");

    property p_flag_clear;
        @(posedge clock_i) disable iff (!rst_b_i)
            on_r && !cmp_s2_r |=> !low_voltage_flag_r;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_ro;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) |=> low_voltage_flag_r == $past(on_r && cmp_s2_r);
    endproperty
    a_flag_ro: assert property (p_flag_ro) else $error("flag took a write");

    property p_sleep_no_flag;
        @(posedge clock_i) disable iff (!rst_b_i)
            sleep_i |=> ##1 !low_voltage_flag_r;
    endproperty
    a_sleep_no_flag: assert property (p_sleep_no_flag) else $error("flag during sleep");

    property p_dis_off;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) && !bus_i.wdata[4] |=> !on_r;
    endproperty
    a_dis_off: assert property (p_dis_off) else $error("disable not applied");

    property p_en_store;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) |=> detector_enable_r == $past(bus_i.wdata[4]);
    endproperty
    a_en_store: assert property (p_en_store) else $error("enable bit not stored");

    property p_sel_store;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL)
            |=> threshold_select_r == $past(bus_i.wdata[2:0]);
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("select not stored");

    property p_trip_min;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_CTRL) && bus_i.wdata[2:0] == 3'h0
            |=> trip_r == 16'd1800;
    endproperty
    a_trip_min: assert property (p_trip_min) else $error("lowest trip wrong");

    property p_irq_en_store;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_MFI) |=> lv_irq_enable_r == $past(bus_i.wdata[0]);
    endproperty
    a_irq_en_store: assert property (p_irq_en_store) else $error("irq enable not stored");

    property p_req_sw;
        @(posedge clock_i) disable iff (!rst_b_i)
            hit(bus_i, lvd_pkg::LVD_ADDR_MFI) && !hw_set
            |=> lv_irq_request_r == $past(bus_i.wdata[4]);
    endproperty
    a_req_sw: assert property (p_req_sw) else $error("request not writable");

    property p_hw_wins;
        @(posedge clock_i) disable iff (!rst_b_i)
            hw_set |=> lv_irq_request_r;
    endproperty
    a_hw_wins: assert property (p_hw_wins) else $error("hardware set lost");

    property p_mf_on;
        @(posedge clock_i) disable iff (!rst_b_i)
            lv_irq_request_r && lv_irq_enable_r |-> mf_irq_r;
    endproperty
    a_mf_on: assert property (p_mf_on) else $error("group request missing");

    property p_mf_off;
        @(posedge clock_i) disable iff (!rst_b_i)
            !lv_irq_request_r || !lv_irq_enable_r |-> !mf_irq_r;
    endproperty
    a_mf_off: assert property (p_mf_off) else $error("group request spurious");

    property p_wake_pulse;
        @(posedge clock_i) disable iff (!rst_b_i)
            wake_r |=> !wake_r;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");

    property p_no_wake_busy;
        @(posedge clock_i) disable iff (!rst_b_i)
            !idle_i || lv_irq_request_r |=> !wake_r;
    endproperty
    a_no_wake_busy: assert property (p_no_wake_busy) else $error("wake without idle");

    property p_rd_idle;
        @(posedge clock_i) disable iff (!rst_b_i)
            !bus_i.rd |=> rdata_r == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

    property p_mfi_unused;
        @(posedge clock_i) disable iff (!rst_b_i)
            bus_i.rd && bus_i.addr == lvd_pkg::LVD_ADDR_MFI
            |=> rdata_r[7:5] == 3'h0 && rdata_r[3:1] == 3'h0;
    endproperty
    a_mfi_unused: assert property (p_mfi_unused) else $error("group spare bits set");
endmodule : lvd_ctrl

//--- dv/lvd_tb.sv
`timescale 1ns/1ps
module tb;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    lvd_pkg::lvd_bus_req_t bus = '0;
    logic cmp_low = 1'b0;
    logic sleep = 1'b0;
    logic idle = 1'b0;
    logic [7:0] rdata;
    logic det_on, mf_irq, wake;
    logic [2:0] sel;
    logic [15:0] trip;
    logic rd_p = 1'b0;
    logic [7:0] exp_q[$];
    int error_cnt = 0;
    int checks_done = 0;
    int wake_cnt = 0;
    integer seed = 32'h7975;
    logic [7:0] w;

    always #50 clock_i = ~clock_i;

    lvd_ctrl #(.DELAY_CYC(4)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus),
        .rdata_o(rdata), .cmp_low_i(cmp_low), .sleep_i(sleep), .idle_i(idle),
        .detector_on_o(det_on), .threshold_select_o(sel), .trip_mv_o(trip),
        .mf_irq_o(mf_irq), .wake_o(wake));

    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        checks_done++;
        if (seen !== expv) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask : chk

    task automatic final_report;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask : cyc

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        bus.rd <= 1'b0;
    endtask : rd

    // Read data is only valid in the cycle after the strobe
    always @(posedge clock_i) rd_p <= bus.rd;
    always @(negedge clock_i) begin
        if (rd_p) begin
            chk(rdata, exp_q.pop_front());
        end
    end
    always @(posedge clock_i) if (wake === 1'b1) wake_cnt++;

    initial begin
        cyc(4);
        rst_b_i <= 1'b1;
        chk(trip, 16'd1800);
        chk({det_on, mf_irq, wake, sel}, 16'h0);
        rd(lvd_pkg::LVD_ADDR_CTRL, 8'h00);
        rd(lvd_pkg::LVD_ADDR_MFI, 8'h00);
        for (int i = 0; i < 8; i++) begin
            w = $random(seed);
            w[2:0] = i[2:0];
            wr(lvd_pkg::LVD_ADDR_CTRL, w);
            rd(lvd_pkg::LVD_ADDR_CTRL, w & 8'h17);
            chk(sel, i[2:0]);
            chk(trip, lvd_pkg::TRIP_MV[i]);
            chk({15'h0, det_on}, {15'h0, w[4]});
        end
        wr(2'h1, 8'h01);
        wr(2'h0, 8'h17);
        idle <= 1'b1;
        sleep <= 1'b1;
        cmp_low <= 1'b1;
        cyc(6);
        chk(det_on, 16'h0);
        rd(2'h0, 8'h17);
        sleep <= 1'b0;
        rd(2'h1, 8'h01);
        cyc(10);
        wr(2'h0, 8'hd7);
        rd(2'h0, 8'h37);
        rd(2'h1, 8'h11);
        chk(mf_irq, 16'h1);
        chk(wake_cnt[15:0], 16'h1);
        cmp_low <= 1'b0;
        cyc(6);
        rd(2'h0, 8'h17);
        rd(2'h1, 8'h11);
        wr(2'h1, 8'h01);
        rd(2'h1, 8'h01);
        chk(mf_irq, 16'h0);
        wr(2'h1, 8'h11);
        cmp_low <= 1'b1;
        cyc(12);
        chk(wake_cnt[15:0], 16'h1);
        wr(2'h0, 8'h07);
        cyc(2);
        chk(det_on, 16'h0);
        cyc(4);
        rd(2'h0, 8'h07);
        wr(2'h2, 8'hff);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        @(posedge clock_i) rst_b_i <= 1'b0;
        cyc(2);
        rst_b_i <= 1'b1;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        cyc(3);
        final_report();
    end

    initial begin
        cyc(5000);
        error_cnt++;
        final_report();
    end
endmodule : tb
